/* File: design/nv_seq.sv */
// Purpose: store/restore, sleep and standby sequencer of a serial nvSRAM
// Assumes: serial decoder on MCLK_I supplies command and access strobes
// Notes:   pins from outside pass a two-stage synchroniser
//
// Summary of operation
// - power-up restore ends within 20/40 ms
// - skip clean pin or power-loss save (soft save always runs), else finish within 8 ms
// - writes stay enabled briefly after a pin or power-loss save starts
// - accesses ignored during save, restore, low supply
// - save/restore lock serial access; restore 600 us
// - soft commands acted on within 500 us
// - accessible within 20/40 ms after wake
// - sleep entered within 8 ms of instruction
// - standby within 100 us of chip deselect
// - active within 5 us after busy pin high
// - drive busy pin high at most 500 ns
// - array disabled while busy pin held low

`timescale 1ns/1ps

module nv_seq
  import nv_seq_pkg::*;
#(
  parameter int PU_RESTORE_CYC_P    = POWERUP_RESTORE_CYC,
  parameter int PU_RESTORE_LV_CYC_P = POWERUP_RESTORE_LV_CYC,
  parameter int SAVE_CYC_P          = SAVE_CYC,
  parameter int RESTORE_CYC_P       = RESTORE_CYC,
  parameter int SOFT_CYC_P          = SOFT_CYC,
  parameter int WAKE_CYC_P          = WAKE_CYC,
  parameter int WAKE_LV_CYC_P       = WAKE_LV_CYC,
  parameter int SLEEP_CYC_P         = SLEEP_CYC,
  parameter int STANDBY_CYC_P       = STANDBY_CYC
) (
  input  wire logic      MCLK_I,
  input  wire logic      SYS_RST_I,
  input  wire logic      CLK_EN_I,
  input  wire logic      SUPPLY_OK_I,
  input  wire logic      LOW_VOLT_I,
  input  wire logic      CS_N_I,
  input  wire logic      SAVE_BUSY_PIN_I,
  input  wire soft_cmd_s SOFT_CMD_I,
  input  wire logic      MEM_RD_REQ_I,
  input  wire logic      MEM_WR_REQ_I,
  output logic           SAVE_BUSY_PIN_O,
  output logic           SAVE_BUSY_PIN_OE_O,
  output logic           MEM_RD_ACK_O,
  output logic           MEM_WR_ACK_O,
  output logic           NV_SAVE_O,
  output logic           NV_RESTORE_O,
  output status_s        STATUS_O
);

  // ********************************************************
  // input synchronisers
  // ********************************************************
  logic [SYNC_W-1:0] sync1_q;
  logic [SYNC_W-1:0] sync2_q;
  logic [SYNC_W-1:0] pin_raw;
  logic [1:0]        own_low_q;
  logic              cs_n_prev_q;
  logic              supply_ok;
  logic              pin_low;
  logic              cs_n;
  logic              low_volt;
  logic              cs_fall;

  assign pin_raw = {LOW_VOLT_I, CS_N_I, SAVE_BUSY_PIN_I, SUPPLY_OK_I};

  // own low drive delayed two stages, in step with the synchronised pin
  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I) begin
      sync1_q     <= SYNC_RST;
      sync2_q     <= SYNC_RST;
      own_low_q   <= '0;
      cs_n_prev_q <= 1'b1;
    end else if (CLK_EN_I) begin
      sync1_q     <= pin_raw;
      sync2_q     <= sync1_q;
      own_low_q   <= {own_low_q[0], SAVE_BUSY_PIN_OE_O & ~SAVE_BUSY_PIN_O};
      cs_n_prev_q <= cs_n;
    end
  end

  assign supply_ok = sync2_q[SY_SUPPLY];
  // only a low from outside counts, never our own drive
  assign pin_low   = ~sync2_q[SY_BUSY] & ~own_low_q[1];
  assign cs_n      = sync2_q[SY_CS_N];
  assign low_volt  = sync2_q[SY_LOWV];
  assign cs_fall   = cs_n_prev_q & ~cs_n;

  // ********************************************************
  // sequencer state
  // ********************************************************
  seq_state_e  state_q;
  seq_state_e  state_d;
  logic [TMR_W-1:0] tmr_q;
  logic        done;
  logic        dirty_q;
  logic        save_en_q;
  soft_cmd_s   soft_q;
  logic        soft_any;
  seq_state_e  pf_state;

  assign done     = (tmr_q == '0);
  assign soft_any = |SOFT_CMD_I;
  // power loss: save only when armed and a write is pending
  assign pf_state = (dirty_q && save_en_q) ? ST_GRACE : ST_OFF;

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_OFF: begin
        if (supply_ok) begin
          state_d = ST_PU_RESTORE;
        end
      end
      ST_PU_RESTORE, ST_SW_RESTORE, ST_WAKE: begin
        if (!supply_ok) begin
          state_d = ST_OFF;
        end else if (done) begin
          state_d = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (!supply_ok) begin
          state_d = pf_state;
        end else if (pin_low) begin
          state_d = dirty_q ? ST_GRACE : ST_RELEASE;
        end else if (soft_any) begin
          state_d = ST_SOFT;
        end
      end
      ST_GRACE:   if (done) state_d = ST_SAVE;
      ST_SAVE:    if (done) state_d = ST_BUSY_HI;
      ST_BUSY_HI: if (done) state_d = supply_ok ? ST_RELEASE : ST_OFF;
      ST_RELEASE: begin
        if (!supply_ok) begin
          state_d = pf_state;
        end else if (done && !pin_low) begin
          state_d = ST_IDLE;
        end
      end
      ST_SOFT: begin
        if (!supply_ok) begin
          state_d = pf_state;
        end else if (done) begin
          if (soft_q.save) begin
            state_d = ST_SAVE;
          end else if (soft_q.restore) begin
            state_d = ST_SW_RESTORE;
          end else if (soft_q.sleep) begin
            state_d = ST_SLEEP_ENTRY;
          end else begin
            state_d = ST_IDLE;
          end
        end
      end
      ST_SLEEP_ENTRY: begin
        if (!supply_ok) begin
          state_d = ST_OFF;
        end else if (done) begin
          state_d = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (!supply_ok) begin
          state_d = ST_OFF;
        end else if (cs_fall) begin
          state_d = ST_WAKE;
        end
      end
      default: begin
        state_d = ST_OFF;
      end
    endcase
  end

  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I) begin
      state_q <= ST_OFF;
    end else if (CLK_EN_I) begin
      state_q <= state_d;
    end
  end

  // ********************************************************
  // interval timer, loaded on each state change
  // ********************************************************
  function automatic logic [TMR_W-1:0] load_of(input seq_state_e s, input logic lv);
    int n;
    n = 0;
    case (s)
      ST_PU_RESTORE:  n = lv ? PU_RESTORE_LV_CYC_P : PU_RESTORE_CYC_P;
      ST_GRACE:       n = GRACE_CYC;
      ST_SAVE:        n = SAVE_CYC_P;
      ST_BUSY_HI:     n = BUSY_HI_CYC;
      ST_RELEASE:     n = RELEASE_CYC;
      ST_SOFT:        n = SOFT_CYC_P;
      ST_SW_RESTORE:  n = RESTORE_CYC_P;
      ST_SLEEP_ENTRY: n = SLEEP_CYC_P;
      ST_WAKE:        n = lv ? WAKE_LV_CYC_P : WAKE_CYC_P;
      default:        n = 0;
    endcase
    // count n spans n cycles including the entry cycle
    return (n > 0) ? TMR_W'(n - 1) : '0;
  endfunction

  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I) begin
      tmr_q <= '0;
    end else if (CLK_EN_I) begin
      if (state_d != state_q) begin
        tmr_q <= load_of(state_d, low_volt);
      end else if (state_q == ST_RELEASE && pin_low) begin
        tmr_q <= load_of(ST_RELEASE, low_volt);
      end else if (!done) begin
        tmr_q <= tmr_q - TMR_W'(1);
      end
    end
  end

  // ********************************************************
  // soft commands and save arming
  // ********************************************************
  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I) begin
      soft_q <= '0;
    end else if (CLK_EN_I) begin
      if (state_q == ST_IDLE && state_d == ST_SOFT) begin
        soft_q <= SOFT_CMD_I;
      end
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I) begin
      save_en_q <= 1'b1;
    end else if (CLK_EN_I) begin
      if (state_q == ST_SOFT && done && supply_ok) begin
        if (soft_q.save_en) begin
          save_en_q <= 1'b1;
        end else if (soft_q.save_dis) begin
          save_en_q <= 1'b0;
        end
      end
    end
  end

  // ********************************************************
  // access gating and write tracking
  // ********************************************************
  logic rd_ok;
  logic wr_ok;
  logic wr_take;
  logic nv_end;

  assign rd_ok   = (state_q == ST_IDLE) && supply_ok && !pin_low;
  assign wr_ok   = rd_ok || (state_q == ST_GRACE);
  assign wr_take = MEM_WR_REQ_I && wr_ok;
  assign nv_end  = done && (state_q == ST_SAVE || state_q == ST_SW_RESTORE
                            || state_q == ST_PU_RESTORE);

  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I) begin
      dirty_q <= 1'b0;
    end else if (CLK_EN_I) begin
      // a write in the final cycle still marks the array dirty
      if (wr_take) begin
        dirty_q <= 1'b1;
      end else if (nv_end) begin
        dirty_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I) begin
      MEM_RD_ACK_O <= 1'b0;
      MEM_WR_ACK_O <= 1'b0;
    end else if (CLK_EN_I) begin
      MEM_RD_ACK_O <= MEM_RD_REQ_I && rd_ok;
      MEM_WR_ACK_O <= wr_take;
    end
  end

  // ********************************************************
  // standby after deselect
  // ********************************************************
  logic [STBY_W-1:0] stby_cnt_q;
  logic              standby_q;

  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I) begin
      stby_cnt_q <= '0;
      standby_q  <= 1'b0;
    end else if (CLK_EN_I) begin
      if (!cs_n || state_q != ST_IDLE) begin
        stby_cnt_q <= '0;
        standby_q  <= 1'b0;
      end else if (stby_cnt_q == STBY_W'(STANDBY_CYC_P - 1)) begin
        standby_q  <= 1'b1;
      end else begin
        stby_cnt_q <= stby_cnt_q + STBY_W'(1);
      end
    end
  end

  // ********************************************************
  // registered outputs
  // ********************************************************
  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I) begin
      SAVE_BUSY_PIN_O    <= 1'b0;
      SAVE_BUSY_PIN_OE_O <= 1'b0;
      NV_SAVE_O          <= 1'b0;
      NV_RESTORE_O       <= 1'b0;
      STATUS_O           <= '0;
    end else if (CLK_EN_I) begin
      // low while busy, high briefly after a save, then released
      SAVE_BUSY_PIN_O    <= (state_d == ST_BUSY_HI);
      SAVE_BUSY_PIN_OE_O <= (state_d == ST_GRACE) || (state_d == ST_SAVE)
                            || (state_d == ST_PU_RESTORE) || (state_d == ST_BUSY_HI);
      NV_SAVE_O          <= (state_d == ST_SAVE);
      NV_RESTORE_O       <= (state_d == ST_PU_RESTORE) || (state_d == ST_SW_RESTORE);
      STATUS_O.ready      <= (state_d == ST_IDLE);
      STATUS_O.standby    <= standby_q;
      STATUS_O.asleep     <= (state_d == ST_SLEEP);
      STATUS_O.saving     <= (state_d == ST_GRACE) || (state_d == ST_SAVE);
      STATUS_O.restoring  <= (state_d == ST_PU_RESTORE) || (state_d == ST_SW_RESTORE);
      STATUS_O.save_armed <= save_en_q;
      STATUS_O.dirty      <= dirty_q;
    end
  end

endmodule

/* File: design/nv_seq_pkg.sv */
// Purpose: constants and carriers for the store/restore sequencer
// Assumes: clock of 8 ns period
// Notes:   all latencies are maximum times, so cycle counts round down

package nv_seq_pkg;

  // ********************************************************
  // clock and unit scaling
  // ********************************************************
  localparam int CLK_PERIOD_NS = 8;
  localparam int NS_PER_US     = 1000;
  localparam int NS_PER_MS     = 1000000;

  // ********************************************************
  // timing figures in their own units
  // ********************************************************
  localparam int POWERUP_RESTORE_DURATION_MS    = 20;
  localparam int POWERUP_RESTORE_DURATION_LV_MS = 40;
  localparam int SAVE_DURATION_MS               = 8;
  localparam int WRITE_GRACE_WINDOW_NS          = 25;
  localparam int RESTORE_DURATION_US            = 600;
  localparam int SOFT_COMMAND_LATENCY_US        = 500;
  localparam int WAKE_LATENCY_MS                = 20;
  localparam int WAKE_LATENCY_LV_MS             = 40;
  localparam int SLEEP_ENTRY_LATENCY_MS         = 8;
  localparam int STANDBY_ENTRY_LATENCY_US       = 100;
  localparam int BUSY_RELEASE_TO_ACTIVE_US      = 5;
  localparam int BUSY_HIGH_DRIVE_TIME_NS        = 500;

  // ********************************************************
  // derived cycle counts
  // ********************************************************
  localparam int POWERUP_RESTORE_CYC    = POWERUP_RESTORE_DURATION_MS * NS_PER_MS / CLK_PERIOD_NS;
  localparam int POWERUP_RESTORE_LV_CYC = POWERUP_RESTORE_DURATION_LV_MS * NS_PER_MS
                                          / CLK_PERIOD_NS;
  localparam int SAVE_CYC               = SAVE_DURATION_MS * NS_PER_MS / CLK_PERIOD_NS;
  localparam int RESTORE_CYC            = RESTORE_DURATION_US * NS_PER_US / CLK_PERIOD_NS;
  localparam int SOFT_CYC               = SOFT_COMMAND_LATENCY_US * NS_PER_US / CLK_PERIOD_NS;
  localparam int WAKE_CYC               = WAKE_LATENCY_MS * NS_PER_MS / CLK_PERIOD_NS;
  localparam int WAKE_LV_CYC            = WAKE_LATENCY_LV_MS * NS_PER_MS / CLK_PERIOD_NS;
  localparam int SLEEP_CYC              = SLEEP_ENTRY_LATENCY_MS * NS_PER_MS / CLK_PERIOD_NS;
  localparam int STANDBY_CYC            = STANDBY_ENTRY_LATENCY_US * NS_PER_US / CLK_PERIOD_NS;
  localparam int GRACE_CYC              = WRITE_GRACE_WINDOW_NS / CLK_PERIOD_NS;
  localparam int RELEASE_CYC            = BUSY_RELEASE_TO_ACTIVE_US * NS_PER_US / CLK_PERIOD_NS;
  localparam int BUSY_HI_CYC            = BUSY_HIGH_DRIVE_TIME_NS / CLK_PERIOD_NS;

  localparam int TMR_W   = 23;
  localparam int STBY_W  = 14;
  localparam int SYNC_W  = 4;

  // synchroniser lane positions
  localparam int SY_SUPPLY = 0;
  localparam int SY_BUSY   = 1;
  localparam int SY_CS_N   = 2;
  localparam int SY_LOWV   = 3;

  localparam logic [SYNC_W-1:0] SYNC_RST = 4'hE;

  // ********************************************************
  // carriers and states
  // ********************************************************
  typedef struct packed {
    logic save;
    logic restore;
    logic save_en;
    logic save_dis;
    logic sleep;
  } soft_cmd_s;

  typedef struct packed {
    logic ready;
    logic standby;
    logic asleep;
    logic saving;
    logic restoring;
    logic save_armed;
    logic dirty;
  } status_s;

  typedef enum logic [3:0] {
    ST_OFF         = 4'h0,
    ST_PU_RESTORE  = 4'h1,
    ST_IDLE        = 4'h2,
    ST_GRACE       = 4'h3,
    ST_SAVE        = 4'h4,
    ST_BUSY_HI     = 4'h5,
    ST_RELEASE     = 4'h6,
    ST_SOFT        = 4'h7,
    ST_SW_RESTORE  = 4'h8,
    ST_SLEEP_ENTRY = 4'h9,
    ST_SLEEP       = 4'hA,
    ST_WAKE        = 4'hB
  } seq_state_e;

endpackage

/* File: verification/nv_host_model.sv */
// Purpose: host side of the serial link: chip select, link clock, save request
// Assumes: bench asks for frames and save pulses on its own clock
// Notes:   link clock idles low outside frames

`timescale 1ns/1ps

module nv_host_model (
  input  wire logic clk_i,
  input  wire logic frame_i,
  input  wire logic save_req_i,
  output logic      cs_n_o,
  output logic      sck_o,
  output logic      save_low_o
);
  initial begin
    cs_n_o     = 1'b1;
    save_low_o = 1'b0;
  end
  // bench holds a request at least 4 cycles (32 ns)
  always @(posedge clk_i) begin
    cs_n_o     <= ~frame_i;
    save_low_o <= save_req_i;
  end
  // 64 ns period, only inside frames
  initial begin
    sck_o = 1'b0;
    #3;
    forever begin
      #32;
      sck_o = cs_n_o ? 1'b0 : ~sck_o;
    end
  end
endmodule

/* File: verification/nv_seq_chk.sv */
// Purpose: timing and lockout checks on the sequencer ports
// Assumes: one clock domain, synchronous active-high reset
// Notes:   bound to every nv_seq instance

`timescale 1ns/1ps

module nv_seq_chk
  import nv_seq_pkg::*;
#(
  parameter int SAVE_CYC_P    = SAVE_CYC,
  parameter int STANDBY_CYC_P = STANDBY_CYC
) (
  input wire logic    MCLK_I,
  input wire logic    SYS_RST_I,
  input wire logic    SUPPLY_OK_I,
  input wire logic    CS_N_I,
  input wire logic    SAVE_BUSY_PIN_I,
  input wire logic    MEM_RD_REQ_I,
  input wire logic    MEM_WR_REQ_I,
  input wire logic    SAVE_BUSY_PIN_O,
  input wire logic    SAVE_BUSY_PIN_OE_O,
  input wire logic    MEM_RD_ACK_O,
  input wire logic    MEM_WR_ACK_O,
  input wire logic    NV_SAVE_O,
  input wire logic    NV_RESTORE_O,
  input wire status_s STATUS_O
);
  // ********************************
  // run-length counters
  // ********************************
  logic [15:0] hi_q;
  logic [23:0] sv_q;
  logic [15:0] sb_q;
  logic        req;
  logic        ack;

  assign req = MEM_RD_REQ_I || MEM_WR_REQ_I;
  assign ack = MEM_RD_ACK_O || MEM_WR_ACK_O;

  always_ff @(posedge MCLK_I) begin
    hi_q <= (SYS_RST_I || !(SAVE_BUSY_PIN_OE_O && SAVE_BUSY_PIN_O)) ? '0 : hi_q + 16'h1;
  end
  always_ff @(posedge MCLK_I) begin
    sv_q <= (SYS_RST_I || !NV_SAVE_O) ? '0 : sv_q + 24'h1;
  end
  always_ff @(posedge MCLK_I) begin
    sb_q <= (SYS_RST_I || !CS_N_I || !STATUS_O.ready || STATUS_O.standby) ? '0 : sb_q + 16'h1;
  end

  // ********************************
  // properties
  // ********************************
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (SYS_RST_I);

  AST_RD_ACK_CAUSE: assert property (MEM_RD_ACK_O |-> $past(MEM_RD_REQ_I))
    else $error("read ack without request");
  AST_WR_ACK_CAUSE: assert property (MEM_WR_ACK_O |-> $past(MEM_WR_REQ_I))
    else $error("write ack without request");
  AST_LOW_SUPPLY_LOCK: assert property ((!SUPPLY_OK_I [*8]) ##0 req |=> !ack)
    else $error("access acked with supply low");
  AST_PIN_LOW_LOCK: assert property ((!SAVE_BUSY_PIN_I [*8]) ##0 req |=> !ack)
    else $error("access acked with busy pin low");
  AST_RESTORE_LOCK: assert property (req && NV_RESTORE_O |=> !NV_RESTORE_O || !ack)
    else $error("access acked during restore");
  AST_BUSY_HIGH_MAX: assert property (hi_q <= BUSY_HI_CYC)
    else $error("busy pin driven high too long");
  AST_SAVE_LEN: assert property (sv_q <= SAVE_CYC_P + GRACE_CYC)
    else $error("save runs too long");
  AST_STANDBY_BOUND: assert property (sb_q <= STANDBY_CYC_P + 4)
    else $error("standby not entered in time");

  cover property ($rose(NV_SAVE_O));
  cover property ($rose(STATUS_O.standby));
  cover property ($rose(STATUS_O.asleep));
endmodule

bind nv_seq nv_seq_chk #(.SAVE_CYC_P(SAVE_CYC_P), .STANDBY_CYC_P(STANDBY_CYC_P)) nv_seq_chk_i (
  .MCLK_I(MCLK_I), .SYS_RST_I(SYS_RST_I), .SUPPLY_OK_I(SUPPLY_OK_I), .CS_N_I(CS_N_I),
  .SAVE_BUSY_PIN_I(SAVE_BUSY_PIN_I), .MEM_RD_REQ_I(MEM_RD_REQ_I), .MEM_WR_REQ_I(MEM_WR_REQ_I),
  .SAVE_BUSY_PIN_O(SAVE_BUSY_PIN_O), .SAVE_BUSY_PIN_OE_O(SAVE_BUSY_PIN_OE_O),
  .MEM_RD_ACK_O(MEM_RD_ACK_O), .MEM_WR_ACK_O(MEM_WR_ACK_O), .NV_SAVE_O(NV_SAVE_O),
  .NV_RESTORE_O(NV_RESTORE_O), .STATUS_O(STATUS_O));

/* File: verification/nv_seq_test.sv */
// Purpose: self-checking bench for the store/restore sequencer
// Assumes: shortened timer parameters, normal-voltage variant except the low-voltage power-up in t_ploss
// Notes:   busy-high and release spans are fixed at 62 and 625 cycles

`timescale 1ns/1ps

module nv_seq_test
  import nv_seq_pkg::*;
;
  localparam int PU    = 40;
  localparam int SV    = 30;
  localparam int RS    = 30;
  localparam int SF    = 20;
  localparam int WK    = 30;
  localparam int SL    = 20;
  localparam int SB    = 16;
  localparam int I_RDY = 8;
  localparam int I_SB  = 7;
  localparam int I_SLP = 6;
  localparam int I_SVG = 5;
  localparam int I_RST = 4;
  localparam int I_ARM = 3;
  localparam int I_DRT = 2;
  localparam int I_NSV = 1;
  localparam int I_NRS = 0;

  logic      clk   = 1'b0;
  logic      rst   = 1'b1;
  logic      sup   = 1'b0;
  logic      rd    = 1'b0;
  logic      wr    = 1'b0;
  logic      frame = 1'b0;
  logic      preq  = 1'b0;
  soft_cmd_s cmd   = '0;
  logic      lv    = 1'b0;
  logic      cs_n;
  logic      slow;
  logic      pin_o;
  logic      oe;
  logic      ack_r;
  logic      ack_w;
  logic      nsv;
  logic      nrs;
  status_s   st;
  wire [8:0] obs;
  wire       pin;
  int        err_count = 0;
  int        compares  = 0;

  assign pin = slow ? 1'b0 : (oe ? pin_o : 1'b1);
  assign obs = {st, nsv, nrs};
  always #4 clk = ~clk;

  nv_seq #(.PU_RESTORE_CYC_P(PU), .PU_RESTORE_LV_CYC_P(60), .SAVE_CYC_P(SV),
    .RESTORE_CYC_P(RS), .SOFT_CYC_P(SF), .WAKE_CYC_P(WK), .WAKE_LV_CYC_P(60),
    .SLEEP_CYC_P(SL), .STANDBY_CYC_P(SB)) nv_seq_i (
    .MCLK_I(clk), .SYS_RST_I(rst), .CLK_EN_I(1'b1), .SUPPLY_OK_I(sup), .LOW_VOLT_I(lv),
    .CS_N_I(cs_n), .SAVE_BUSY_PIN_I(pin), .SOFT_CMD_I(cmd), .MEM_RD_REQ_I(rd),
    .MEM_WR_REQ_I(wr), .SAVE_BUSY_PIN_O(pin_o), .SAVE_BUSY_PIN_OE_O(oe), .MEM_RD_ACK_O(ack_r),
    .MEM_WR_ACK_O(ack_w), .NV_SAVE_O(nsv), .NV_RESTORE_O(nrs), .STATUS_O(st));

  nv_host_model nv_host_model_i (.clk_i(clk), .frame_i(frame), .save_req_i(preq),
    .cs_n_o(cs_n), .sck_o(), .save_low_o(slow));

  // ********************************
  // shared tasks
  // ********************************
  task automatic chk(input logic g, input logic e);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic wt(input int i, input logic v, input int n);
    int k;
    k = 0;
    while (obs[i] !== v && k < n) begin
      @(posedge clk);
      #1;
      k++;
    end
    chk(obs[i], v);
  endtask

  task automatic acc(input logic w, input logic e);
    @(posedge clk);
    if (w) wr <= 1'b1;
    else rd <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    #1;
    chk(w ? ack_w : ack_r, e);
  endtask

  task automatic sc(input soft_cmd_s c);
    @(posedge clk);
    cmd <= c;
    @(posedge clk);
    cmd <= '0;
  endtask

  task automatic final_report();
    $display("compares=%0d err_count=%0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ********************************
  // scenarios
  // ********************************
  task automatic t_power();
    @(posedge clk);
    sup <= 1'b1;
    wt(I_NRS, 1'b1, 10);
    acc(1'b0, 1'b0);
    wt(I_RDY, 1'b1, PU + 10);
    chk(obs[I_ARM], 1'b1);
  endtask

  task automatic t_skip();
    logic seen;
    seen = 1'b0;
    @(posedge clk);
    preq <= 1'b1;
    repeat (3) @(posedge clk);
    acc(1'b0, 1'b0);
    preq <= 1'b0;
    repeat (30) begin
      @(posedge clk);
      seen = seen | nsv;
    end
    chk(seen, 1'b0);
    wt(I_RDY, 1'b1, 700);
  endtask

  task automatic t_access();
    acc(1'b0, 1'b1);
    acc(1'b1, 1'b1);
    wt(I_DRT, 1'b1, 3);
  endtask

  task automatic t_pin_save();
    logic seen;
    seen = 1'b0;
    @(posedge clk);
    wr   <= 1'b1;
    preq <= 1'b1;
    for (int k = 0; k < 12; k++) begin
      @(posedge clk);
      #1;
      if (k >= 4 && ack_w === 1'b1) seen = 1'b1;
    end
    chk(seen, 1'b1);
    chk(ack_w, 1'b0);
    @(posedge clk);
    wr   <= 1'b0;
    preq <= 1'b0;
    wt(I_NSV, 1'b1, 5);
    chk(obs[I_SVG], 1'b1);
    acc(1'b0, 1'b0);
    wt(I_NSV, 1'b0, SV + 10);
    wt(I_RDY, 1'b1, 710);
    chk(pin, 1'b1);
  endtask

  task automatic t_standby();
    @(posedge clk);
    frame <= 1'b1;
    repeat (SB + 8) @(posedge clk);
    #1;
    chk(obs[I_SB], 1'b0);
    @(posedge clk);
    frame <= 1'b0;
    wt(I_SB, 1'b1, SB + 8);
  endtask

  task automatic t_soft();
    sc(5'h08);
    wt(I_RDY, 1'b0, 3);
    wt(I_NRS, 1'b1, SF + 4);
    chk(obs[I_RST], 1'b1);
    acc(1'b0, 1'b0);
    wt(I_NRS, 1'b0, RS + 4);
    wt(I_RDY, 1'b1, 6);
    sc(5'h02);
    wt(I_ARM, 1'b0, SF + 4);
    wt(I_RDY, 1'b1, 6);
    sc(5'h04);
    wt(I_ARM, 1'b1, SF + 4);
    wt(I_RDY, 1'b1, 6);
    sc(5'h10);
    wt(I_NSV, 1'b1, SF + 4);
    acc(1'b1, 1'b0);
    wt(I_RDY, 1'b1, SV + 700);
  endtask

  task automatic t_sleep();
    sc(5'h01);
    wt(I_RDY, 1'b0, 3);
    wt(I_SLP, 1'b1, SF + SL + 6);
    acc(1'b0, 1'b0);
    frame <= 1'b1;
    wt(I_RDY, 1'b1, WK + 8);
    frame <= 1'b0;
  endtask

  task automatic t_ploss();
    acc(1'b1, 1'b1);
    sup <= 1'b0;
    wt(I_NSV, 1'b1, 12);
    wt(I_NSV, 1'b0, SV + 10);
    acc(1'b0, 1'b0);
    repeat (BUSY_HI_CYC + 4) @(posedge clk);
    #1;
    chk(oe, 1'b0);
    @(posedge clk);
    lv  <= 1'b1;
    sup <= 1'b1;
    wt(I_NRS, 1'b1, 12);
    repeat (PU + 4) @(posedge clk);
    #1;
    chk(obs[I_RDY], 1'b0);
    wt(I_RDY, 1'b1, 30);
  endtask

  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_power();
    t_skip();
    t_access();
    t_pin_save();
    t_standby();
    t_soft();
    t_sleep();
    t_ploss();
    final_report();
  end

  initial begin
    #100000;
    err_count++;
    final_report();
  end
endmodule
